// ===== bench/bidir_port_with_shared_outputs_bench.sv
// Register-level testbench for the three-port I/O block.
`timescale 1ns/10ps
`default_nettype none
module bidir_port_with_shared_outputs_bench;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic clock, rst, ce, tone_opt, buzz_opt, timer_on, timer_overflow, buzzer_out;
   logic [2:0] pullup_opt, pullup_en;
   logic [7:0] rdata;
   logic [19:0] pad_in, ext_en, ext_val;
   logic irq0, irq1, tmr_in, wake, seen;
   bp_pkg::bp_req_s req;
   bp_pkg::bp_pad_s pad;
   int err_total, n_tests;
   logic [7:0] ra [7] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h18, 8'h19, 8'h16};
   logic [7:0] re [7] = '{8'hFF, 8'hFF, 8'h3F, 8'h3F, 8'h77, 8'h77, 8'h00};
   bp_port dut (.clock(clock), .rst(rst), .ce(ce), .req(req), .rdata(rdata),
      .pad_in(pad_in), .pad(pad), .pullup_en(pullup_en), .tone_opt(tone_opt),
      .buzz_opt(buzz_opt), .pullup_opt(pullup_opt), .timer_on(timer_on),
      .timer_overflow(timer_overflow), .buzzer_out(buzzer_out),
      .external_irq_zero(irq0), .external_irq_one(irq1),
      .timer_event_input(tmr_in), .wake(wake));
   bp_pin_model pins (.clock(clock), .pad(pad), .pullup_en(pullup_en),
      .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   // One access: request launched after an edge, taken at the next one.
   task automatic acc(input logic r, input bp_pkg::bp_op_e o, input logic [2:0] b,
                      input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      req <= '{rd: r, wr: ~r, op: o, bit_sel: b, addr: a, wdata: d};
      @(posedge clock);
      req <= '0;
      #1;
   endtask
   // Compare and count; mismatches print at once.
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Let a few edges pass, then sample settled outputs.
   task automatic wait_n(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // Pulse the timer overflow for one cycle.
   task automatic ovf();
      @(posedge clock);
      timer_overflow <= 1'b1;
      @(posedge clock);
      timer_overflow <= 1'b0;
      wait_n(2);
   endtask
   // Verdict, printed once from here only.
   task automatic end_of_test();
      $display("errors=%0d checks=%0d", err_total, n_tests);
      if (err_total == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ----------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // The sequence needs about a hundred cycles; this limit is generous.
   initial begin
      repeat (3000) @(posedge clock);
      err_total++;
      end_of_test();
   end
   initial begin
      rst = 1'b1; ce = 1'b1; req = '0; tone_opt = 1'b0; buzz_opt = 1'b0; timer_on = 1'b0;
      timer_overflow = 1'b0; buzzer_out = 1'b0; pullup_opt = 3'h7;
      ext_en = '0; ext_val = '0; err_total = 0; n_tests = 0;
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      wait_n(3);
      chk(pad.oe, 20'h00000);
      chk(pad.out, 20'hFFFFF);
      // Reset values, pull-ups on inputs, absent bits and an unmapped place.
      for (int i = 0; i < 7; i++) begin
         acc(1'b1, bp_pkg::BP_OP_WRITE, 3'h0, ra[i], 8'h00);
         chk({12'h000, rdata}, {12'h000, re[i]});
      end
      // Port A as output: reads return the latch and the pins drive it.
      acc(1'b0, bp_pkg::BP_OP_WRITE, 3'h0, 8'h12, 8'hA5);
      acc(1'b0, bp_pkg::BP_OP_WRITE, 3'h0, 8'h13, 8'h00);
      acc(1'b1, bp_pkg::BP_OP_WRITE, 3'h0, 8'h12, 8'h00);
      chk({12'h000, rdata}, 20'h000A5);
      wait_n(1);
      chk({pad.oe[7:0], pad.out[7:0]}, 20'h0FFA5);
      // Upper nibble back to input: pads are read, low nibble stays latched.
      acc(1'b0, bp_pkg::BP_OP_WRITE, 3'h0, 8'h13, 8'hF0);
      ext_en <= 20'h000F0;
      ext_val <= 20'h00030;
      wait_n(3);
      acc(1'b1, bp_pkg::BP_OP_WRITE, 3'h0, 8'h12, 8'h00);
      chk({12'h000, rdata}, 20'h00035);
      // A falling input on port A wakes the device.
      seen = 1'b0;
      ext_val <= 20'h00010;
      repeat (6) begin
         wait_n(1);
         if (wake === 1'b1) seen = 1'b1;
      end
      chk({19'h0, seen}, 20'h00001);
      // Shared port D pins reach the interrupt and timer inputs.
      ext_en <= 20'hE00F0;
      ext_val <= 20'hA0010;
      wait_n(4);
      chk({17'h0, tmr_in, irq1, irq0}, 20'h00005);
      // Bit operations on port D read, modify and write back.
      acc(1'b0, bp_pkg::BP_OP_WRITE, 3'h0, 8'h19, 8'h00);
      acc(1'b0, bp_pkg::BP_OP_WRITE, 3'h0, 8'h18, 8'h00);
      acc(1'b0, bp_pkg::BP_OP_SET, 3'h6, 8'h18, 8'h00);
      chk({12'h000, rdata}, 20'h00040);
      acc(1'b0, bp_pkg::BP_OP_SET, 3'h0, 8'h18, 8'h00);
      chk({12'h000, rdata}, 20'h00041);
      acc(1'b0, bp_pkg::BP_OP_CLEAR, 3'h6, 8'h18, 8'h00);
      chk({12'h000, rdata}, 20'h00001);
      acc(1'b0, bp_pkg::BP_OP_COMPLEMENT, 3'h0, 8'h18, 8'h00);
      // The complement hands back all eight bits, absent ones included.
      chk({12'h000, rdata}, 20'h000FE);
      acc(1'b1, bp_pkg::BP_OP_WRITE, 3'h0, 8'h18, 8'h00);
      wait_n(1);
      chk({4'h0, rdata, 2'b00, pad.out[19:14]}, 20'h0763E);
      // Tone: a low latch forces the pin low, a high latch passes the tone.
      tone_opt <= 1'b1;
      timer_on <= 1'b1;
      wait_n(2);
      chk({19'h0, pad.out[3]}, 20'h00000);
      acc(1'b0, bp_pkg::BP_OP_SET, 3'h3, 8'h12, 8'h00);
      ovf();
      seen = pad.out[3];
      ovf();
      chk({19'h0, pad.out[3]}, {19'h0, ~seen});
      ovf();
      chk({19'h0, pad.out[3]}, {19'h0, seen});
      // Buzzer pair gated by the bit 0 and bit 1 latches.
      buzz_opt <= 1'b1;
      buzzer_out <= 1'b1;
      wait_n(2);
      chk({18'h0, pad.out[1:0]}, 20'h00001);
      acc(1'b0, bp_pkg::BP_OP_SET, 3'h1, 8'h12, 8'h00);
      buzzer_out <= 1'b0;
      wait_n(2);
      chk({18'h0, pad.out[1:0]}, 20'h00002);
      // Clock enable low: a write is ignored and the latch keeps its value.
      ce <= 1'b0;
      acc(1'b0, bp_pkg::BP_OP_WRITE, 3'h0, 8'h12, 8'h00);
      ce <= 1'b1;
      acc(1'b1, bp_pkg::BP_OP_WRITE, 3'h0, 8'h12, 8'h00);
      chk({12'h000, rdata}, 20'h0001F);
      // Pull-up enables follow the per-port option.
      pullup_opt <= 3'h5;
      wait_n(2);
      chk({17'h0, pullup_en}, 20'h00005);
      end_of_test();
   end
endmodule
`default_nettype wire

// ===== bench/bp_pin_model.sv
// Pin-side model: pull-ups, external drivers and floating lines.
`timescale 1ns/10ps
`default_nettype none
module bp_pin_model (
   // Clock for the floating-line pattern.
   input  wire logic                         clock,
   // Device side.
   input  wire bp_pkg::bp_pad_s              pad,
   input  wire logic [2:0]                   pullup_en,
   // External drivers.
   input  wire logic [bp_pkg::PAD_COUNT-1:0] ext_en,
   input  wire logic [bp_pkg::PAD_COUNT-1:0] ext_val,
   output logic [bp_pkg::PAD_COUNT-1:0]      pad_in
);
   logic        tog; // Flips every cycle so a floating line never looks stable.
   logic [19:0] pu;  // Pull-up per line, spread from the per-port option.
   assign pu = {{6{pullup_en[2]}}, {6{pullup_en[1]}}, {8{pullup_en[0]}}};
   always @(posedge clock) begin
      tog <= (tog === 1'b1) ? 1'b0 : 1'b1;
   end
   // ----------------------------------------------------------------
   // Wire level: device push-pull drive wins, then external, pull-up, float.
   // ----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < 20; i++) begin
         if (pad.oe[i]) begin
            pad_in[i] = pad.out[i];
         end else if (ext_en[i]) begin
            pad_in[i] = ext_val[i];
         end else if (pu[i]) begin
            pad_in[i] = 1'b1;
         end else begin
            pad_in[i] = tog ^ i[0];
         end
      end
   end
endmodule
`default_nettype wire

// ===== hw/bp_pkg.sv
// Constants and carrier types for the three-port bidirectional I/O block.
package bp_pkg;

   // ----------------------------------------------------------------
   // Register locations in data memory
   // ----------------------------------------------------------------
   localparam logic [7:0] PORT_A_DATA_ADDR = 8'h12; // Port A data latch.
   localparam logic [7:0] PORT_A_DIR_ADDR  = 8'h13; // Port A direction.
   localparam logic [7:0] PORT_B_DATA_ADDR = 8'h14; // Port B data latch.
   localparam logic [7:0] PORT_B_DIR_ADDR  = 8'h15; // Port B direction.
   localparam logic [7:0] PORT_D_DATA_ADDR = 8'h18; // Port D data latch.
   localparam logic [7:0] PORT_D_DIR_ADDR  = 8'h19; // Port D direction.

   // ----------------------------------------------------------------
   // Widths, implemented bits and reset values
   // ----------------------------------------------------------------
   localparam int         PAD_COUNT   = 20;     // Bonded lines in total.
   localparam logic [7:0] PORT_B_MASK = 8'h3F;  // Six lines on port B.
   localparam logic [7:0] PORT_D_MASK = 8'h77;  // Bits 3 and 7 absent.
   localparam logic [7:0] LATCH_RESET = 8'hFF;  // Latches reset high.
   localparam logic [7:0] DIR_RESET   = 8'hFF;  // All lines reset as inputs.
   localparam int         BUZZ_BIT    = 0;      // Buzzer on port A bit 0.
   localparam int         BUZZ_N_BIT  = 1;      // Inverted buzzer on bit 1.
   localparam int         TONE_BIT    = 3;      // Tone on port A bit 3.
   localparam int         IRQ0_PAD    = 17;     // Port D bit 4 pad index.
   localparam int         IRQ1_PAD    = 18;     // Port D bit 5 pad index.
   localparam int         TMR_PAD     = 19;     // Port D bit 6 pad index.

   // ----------------------------------------------------------------
   // Access kinds issued by the core
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      BP_OP_WRITE,
      BP_OP_SET,
      BP_OP_CLEAR,
      BP_OP_COMPLEMENT
   } bp_op_e;

   // One core access, sampled at the second phase edge.
   typedef struct packed {
      logic       rd;      // Read strobe.
      logic       wr;      // Write or read-modify-write strobe.
      bp_op_e     op;      // Kind of write.
      logic [2:0] bit_sel; // Bit number for set and clear.
      logic [7:0] addr;    // Data-memory address.
      logic [7:0] wdata;   // Data for a plain write.
   } bp_req_s;

   // Pad drive for all twenty lines.
   typedef struct packed {
      logic [PAD_COUNT-1:0] out; // Level driven when enabled.
      logic [PAD_COUNT-1:0] oe;  // High while the line drives.
   } bp_pad_s;

endpackage

// ===== hw/bp_port.sv
// Three memory-mapped bidirectional ports with shared tone and buzzer pins.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Twenty lines, data at 12H, 14H, 18H.
// - Input reads sample pads, no latching.
// - Output latch holds until rewritten.
// - Direction registers at 13H, 15H, 19H.
// - Dir 1 input reads pad; 0 reads latch.
// - Outputs are push-pull only.
// - Reset sets latches and directions high.
// - Bit operations read, modify, write back.
// - Any port A input line wakes device.
// - Per-port pull-up by option, else float.
// - Tone on port A bit 3 output.
// - Bit 3 latch gates tone or forces low.
// - Tone toggles each timer overflow.
// - Shared pins: buzzer, tone, interrupts, timer.
// - Buzzer pair on port A bits 0, 1.
// - Bit 0/1 latches gate buzzer signals.
// - Tone pin: latch 0 low, else tone.
module bp_port (
   // Clock, reset and enable.
   input  wire logic                         clock,
   input  wire logic                         rst,
   input  wire logic                         ce,
   // Core access.
   input  wire bp_pkg::bp_req_s              req,
   output logic [7:0]                        rdata,
   // Pads.
   input  wire logic [bp_pkg::PAD_COUNT-1:0] pad_in,
   output bp_pkg::bp_pad_s                   pad,
   output logic [2:0]                        pullup_en,
   // Options and shared-function signals.
   input  wire logic                         tone_opt,
   input  wire logic                         buzz_opt,
   input  wire logic [2:0]                   pullup_opt,
   input  wire logic                         timer_on,
   input  wire logic                         timer_overflow,
   input  wire logic                         buzzer_out,
   // Shared-pin inputs and wake-up.
   output logic                              external_irq_zero,
   output logic                              external_irq_one,
   output logic                              timer_event_input,
   output logic                              wake
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   // All state sits in one struct so that one register process holds it.
   // A copy of it is filled each cycle by the next-state logic.
   typedef struct packed {
      logic [7:0]                   port_a;           // Port A latch.
      logic [7:0]                   port_a_direction; // Port A direction.
      logic [7:0]                   port_b;           // Port B latch.
      logic [7:0]                   port_b_direction; // Port B direction.
      logic [7:0]                   port_d;           // Port D latch.
      logic [7:0]                   port_d_direction; // Port D direction.
      logic                         tone;             // Divide-by-two tone.
      logic [bp_pkg::PAD_COUNT-1:0] sync1;            // First sync stage.
      logic [bp_pkg::PAD_COUNT-1:0] sync2;            // Second sync stage.
      logic [7:0]                   a_prev;           // Port A last level.
      logic [7:0]                   rdata;            // Read result.
      bp_pkg::bp_pad_s              pad;              // Pad drive.
      logic [2:0]                   pullup_en;        // Pull-up enables.
      logic                         irq0;             // Interrupt 0 level.
      logic                         irq1;             // Interrupt 1 level.
      logic                         tmr_evt;          // Timer input level.
      logic                         wake;             // Wake pulse.
   } bp_state_s;

   bp_state_s s;       // Registered state.
   bp_state_s next_s;  // Next state.

   // Resolved port values as read by the core.
   logic [7:0] pa_in, pb_in, pd_in;
   logic [7:0] rd_a, rd_b, rd_d;
   logic [7:0] cur;     // Current value at the addressed location.
   logic [7:0] mod;     // Modified value to write back.
   logic [7:0] pa_drv;  // Port A levels after shared-function gating.

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   // Everything is computed from the registered state, so pad and read
   // outputs trail the latches by one cycle; this keeps outputs on flops.
   always_comb begin
      // Start from the held state; each branch below changes only its own fields.
      // Holding by default keeps every field registered without extra enables.
      next_s = s;
      // Pads come from outside; only the second stage is read below.
      // The first stage may go metastable, so nothing else looks at it.
      next_s.sync1 = pad_in;
      next_s.sync2 = s.sync1;
      pa_in = s.sync2[7:0];
      pb_in = {2'h0, s.sync2[13:8]};
      pd_in = {1'b0, s.sync2[19:17], 1'b0, s.sync2[16:14]};
      // Inputs read the pad, outputs read the latch.
      // Absent bits are masked so that they read as zero on a plain read.
      rd_a = (s.port_a_direction & pa_in) | (~s.port_a_direction & s.port_a);
      rd_b = ((s.port_b_direction & pb_in) | (~s.port_b_direction & s.port_b))
             & bp_pkg::PORT_B_MASK;
      rd_d = ((s.port_d_direction & pd_in) | (~s.port_d_direction & s.port_d))
             & bp_pkg::PORT_D_MASK;
      // Address decode; unmapped locations read as zero.
      // The decode runs every cycle; only rd or wr makes its result matter.
      unique case (req.addr)
         bp_pkg::PORT_A_DATA_ADDR: cur = rd_a;
         bp_pkg::PORT_A_DIR_ADDR:  cur = s.port_a_direction;
         bp_pkg::PORT_B_DATA_ADDR: cur = rd_b;
         bp_pkg::PORT_B_DIR_ADDR:  cur = s.port_b_direction & bp_pkg::PORT_B_MASK;
         bp_pkg::PORT_D_DATA_ADDR: cur = rd_d;
         bp_pkg::PORT_D_DIR_ADDR:  cur = s.port_d_direction & bp_pkg::PORT_D_MASK;
         default:                  cur = 8'h00;
      endcase
      // Bit operations start from the whole resolved port state.
      // A set or clear on an input bit copies its pad level into the latch,
      // which software must expect when it later turns the bit to output.
      unique case (req.op)
         bp_pkg::BP_OP_WRITE:      mod = req.wdata;
         bp_pkg::BP_OP_SET:        mod = cur | (8'h01 << req.bit_sel);
         bp_pkg::BP_OP_CLEAR:      mod = cur & ~(8'h01 << req.bit_sel);
         bp_pkg::BP_OP_COMPLEMENT: mod = ~cur;
      endcase
      // The read result is also what a complement-to-accumulator returns.
      if (req.rd || req.wr) begin
         next_s.rdata = req.wr ? mod : cur;
      end
      // Latches change only on a write to their own location.
      // Absent bits are forced high so they look like idle inputs.
      if (req.wr) begin
         unique case (req.addr)
            bp_pkg::PORT_A_DATA_ADDR: next_s.port_a = mod;
            bp_pkg::PORT_A_DIR_ADDR:  next_s.port_a_direction = mod;
            bp_pkg::PORT_B_DATA_ADDR: next_s.port_b = mod | ~bp_pkg::PORT_B_MASK;
            bp_pkg::PORT_B_DIR_ADDR:  next_s.port_b_direction = mod | ~bp_pkg::PORT_B_MASK;
            bp_pkg::PORT_D_DATA_ADDR: next_s.port_d = mod | ~bp_pkg::PORT_D_MASK;
            bp_pkg::PORT_D_DIR_ADDR:  next_s.port_d_direction = mod | ~bp_pkg::PORT_D_MASK;
            default: begin
               // Other addresses belong to other blocks.
            end
         endcase
      end
      // The tone flips on every overflow while the timer runs, halving it.
      // One flop is the whole divider, so there is no count to keep in step.
      if (timer_on && timer_overflow) begin
         next_s.tone = ~s.tone;
      end
      // Shared outputs are gated by their own latch only.
      // The enable still follows the direction bit, so input mode is untouched.
      pa_drv = s.port_a;
      if (buzz_opt) begin
         pa_drv[bp_pkg::BUZZ_BIT]   = s.port_a[bp_pkg::BUZZ_BIT] & buzzer_out;
         pa_drv[bp_pkg::BUZZ_N_BIT] = s.port_a[bp_pkg::BUZZ_N_BIT] & ~buzzer_out;
      end
      if (tone_opt) begin
         // With the timer stopped the tone holds its last level.
         pa_drv[bp_pkg::TONE_BIT] = s.port_a[bp_pkg::TONE_BIT] & s.tone;
      end
      // Push-pull drive: the enable alone decides, both levels are driven.
      // There is no open-drain style, so a driving line sets both levels.
      next_s.pad.out = {s.port_d[6:4], s.port_d[2:0], s.port_b[5:0], pa_drv};
      next_s.pad.oe  = ~{s.port_d_direction[6:4], s.port_d_direction[2:0],
                         s.port_b_direction[5:0], s.port_a_direction};
      next_s.pullup_en = pullup_opt;
      // Shared input functions see the pad whatever the direction.
      // These taps sit beside the port read path and add nothing to it.
      next_s.irq0    = s.sync2[bp_pkg::IRQ0_PAD];
      next_s.irq1    = s.sync2[bp_pkg::IRQ1_PAD];
      next_s.tmr_evt = s.sync2[bp_pkg::TMR_PAD];
      // A falling edge on any port A input line requests wake-up.
      // The previous level resets low, so the first rise after reset cannot
      // look like a fall; an output-mode line never wakes the device.
      next_s.a_prev = pa_in;
      next_s.wake   = |(s.port_a_direction & s.a_prev & ~pa_in);
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Reset leaves every line an input with its latch high.
   // A low clock enable holds every field, the synchronisers included,
   // so a frozen block sees the pads again only two cycles after it wakes.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s                  <= '0;
         s.port_a           <= bp_pkg::LATCH_RESET;
         s.port_a_direction <= bp_pkg::DIR_RESET;
         s.port_b           <= bp_pkg::LATCH_RESET;
         s.port_b_direction <= bp_pkg::DIR_RESET;
         s.port_d           <= bp_pkg::LATCH_RESET;
         s.port_d_direction <= bp_pkg::DIR_RESET;
         s.pad.out          <= {bp_pkg::PAD_COUNT{1'b1}};
      end else if (ce) begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Every output is a plain copy of a state flop.
   assign rdata             = s.rdata;
   assign pad               = s.pad;
   assign pullup_en         = s.pullup_en;
   assign external_irq_zero = s.irq0;
   assign external_irq_one  = s.irq1;
   assign timer_event_input = s.tmr_evt;
   assign wake              = s.wake;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Every check is skipped while reset is high, except the reset check.

   // A plain read of port A returns the mixed pad and latch value.
   read_input_a: assert property (@(posedge clock) disable iff (rst)
      ce && req.rd && !req.wr && req.addr == bp_pkg::PORT_A_DATA_ADDR
      |=> rdata == $past(rd_a))
      else $error("Port A read value wrong.");

   // The port A latch moves only when its own location is written.
   latch_hold_a: assert property (@(posedge clock) disable iff (rst)
      !(ce && req.wr && req.addr == bp_pkg::PORT_A_DATA_ADDR)
      |=> s.port_a == $past(s.port_a))
      else $error("Port A latch changed without a write.");

   // A set lands in the addressed bit of the latch.
   bit_set_a: assert property (@(posedge clock) disable iff (rst)
      ce && req.wr && req.op == bp_pkg::BP_OP_SET && req.addr == bp_pkg::PORT_A_DATA_ADDR
      |=> s.port_a[$past(req.bit_sel)] == 1'b1)
      else $error("Bit set did not reach the latch.");

   // A clear lands in the addressed bit of the latch.
   bit_clear_a: assert property (@(posedge clock) disable iff (rst)
      ce && req.wr && req.op == bp_pkg::BP_OP_CLEAR && req.addr == bp_pkg::PORT_A_DATA_ADDR
      |=> s.port_a[$past(req.bit_sel)] == 1'b0)
      else $error("Bit clear did not reach the latch.");

   // A plain write to the port A direction lands as written.
   dir_write_a: assert property (@(posedge clock) disable iff (rst)
      ce && req.wr && req.op == bp_pkg::BP_OP_WRITE && req.addr == bp_pkg::PORT_A_DIR_ADDR
      |=> s.port_a_direction == $past(req.wdata))
      else $error("Direction write lost.");

   // Port A pad enables trail the direction register by exactly one cycle.
   dir_drive_a: assert property (@(posedge clock) disable iff (rst)
      ce |=> pad.oe[7:0] == ~$past(s.port_a_direction))
      else $error("Port A enable does not follow direction.");

   // Port B enables follow their direction bits the same way.
   port_b_drive_a: assert property (@(posedge clock) disable iff (rst)
      ce |=> pad.oe[13:8] == ~$past(s.port_b_direction[5:0]))
      else $error("Port B enable does not follow direction.");

   // A low bit 3 latch forces the tone pin low.
   tone_gate_a: assert property (@(posedge clock) disable iff (rst)
      ce && tone_opt && !s.port_a[bp_pkg::TONE_BIT]
      |=> !pad.out[bp_pkg::TONE_BIT])
      else $error("Tone pin not forced low.");

   // Every overflow of a running timer flips the tone.
   tone_toggle_a: assert property (@(posedge clock) disable iff (rst)
      ce && timer_on && timer_overflow |=> s.tone != $past(s.tone))
      else $error("Tone did not toggle on overflow.");

   // Without an overflow the tone level holds.
   tone_hold_a: assert property (@(posedge clock) disable iff (rst)
      ce && !(timer_on && timer_overflow) |=> s.tone == $past(s.tone))
      else $error("Tone moved without an overflow.");

   // A high bit 0 latch passes the buzzer signal.
   buzz_gate_a: assert property (@(posedge clock) disable iff (rst)
      ce && buzz_opt && s.port_a[bp_pkg::BUZZ_BIT]
      |=> pad.out[bp_pkg::BUZZ_BIT] == $past(buzzer_out))
      else $error("Buzzer not passed by latch.");

   // A high bit 1 latch passes the inverted buzzer signal.
   buzz_invert_a: assert property (@(posedge clock) disable iff (rst)
      ce && buzz_opt && s.port_a[bp_pkg::BUZZ_N_BIT]
      |=> pad.out[bp_pkg::BUZZ_N_BIT] == !$past(buzzer_out))
      else $error("Inverted buzzer not passed by latch.");

   // A fall on any input-mode port A line raises wake one cycle later.
   wake_edge_a: assert property (@(posedge clock) disable iff (rst)
      ce && |(s.port_a_direction & s.a_prev & ~pa_in) |=> wake)
      else $error("Wake missed on port A fall.");

   // Pull-up enables copy the option one cycle later.
   pullup_follow_a: assert property (@(posedge clock) disable iff (rst)
      ce |=> pullup_en == $past(pullup_opt))
      else $error("Pull-up enable does not follow option.");

   // A low clock enable freezes the port A latch and direction.
   freeze_hold_a: assert property (@(posedge clock) disable iff (rst)
      !ce |=> s.port_a == $past(s.port_a) && s.port_a_direction == $past(s.port_a_direction))
      else $error("State moved while the clock enable was low.");

   // Right after reset every line is an input.
   reset_state_a: assert property (@(posedge clock)
      $fell(rst) |-> s.port_a_direction == bp_pkg::DIR_RESET && pad.oe == '0)
      else $error("Lines not inputs after reset.");

endmodule
`default_nettype wire
